// >>> sim/host_model.sv
// host serial master facing the lamp switch control block
// assumes calls start on a falling core clock edge
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input  wire logic clk_i,
  // serial link
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_n_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // 21 core clocks a half period keeps sclk under 6 MHz
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n_o = 1'b0;
    gap(21);
    for (int i = 15; i >= 0; i--) begin
      si_o = w[i];
      gap(21);
      sclk_o = 1'b1;
      gap(21);
      r[i] = so_oe_n_i ? 1'bx : so_i;
      sclk_o = 1'b0;
    end
    gap(21);
    cs_n_o = 1'b1;
    // si has a pull-down, so a released line reads low
    si_o = 1'b0;
    gap(42);
  endtask
  // a bare select pulse with no clock edges, the calibration reference
  task automatic pulse(input int len);
    cs_n_o = 1'b0;
    gap(len);
    cs_n_o = 1'b1;
    gap(42);
  endtask
endmodule
`default_nettype wire

// >>> sim/lamp_switch_props.sv
// concurrent checks on the ports of the lamp switch mode and pwm control block
// assumes it is bound onto the top module; one clock domain
`timescale 1ns/10ps
`default_nettype none
module lamp_switch_props (
  // clock and reset
  input wire logic                   clk_i,
  input wire logic                   srst_i,
  // pins and flags
  input wire logic                   cs_n_i,
  input wire logic [3:0]             lamp_line_i,
  input wire logic                   wake_i,
  input wire logic                   sleep_release_i,
  input wire logic                   failsafe_select_i,
  input wire logic                   vdd_fail_i,
  input wire logic                   undervoltage_flag_i,
  input wire lamp_switch_pkg::prot_s prot_i,
  // outputs
  input wire logic                   so_oe_n_o,
  input wire logic [3:0]             output_drive_request_o,
  input wire logic                   fault_pin_oe_n_o,
  input wire logic                   normal_mode_flag_o,
  input wire logic                   pwm_clock_failure_flag_o,
  input wire lamp_switch_pkg::mode_e mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // pins pass a filter of about four edges, hence the repetitions
  sleep_entry_a: assert property (
    (!wake_i && !sleep_release_i && lamp_line_i == 4'h0)[*8] |->
    mode_o == lamp_switch_pkg::MODE_SLEEP) else $error("not asleep");
  wake_exit_a: assert property (wake_i[*8] |-> mode_o != lamp_switch_pkg::MODE_SLEEP)
    else $error("asleep while woken");
  sleep_off_a: assert property ((mode_o == lamp_switch_pkg::MODE_SLEEP)[*3] |->
    output_drive_request_o == 4'h0 && !pwm_clock_failure_flag_o) else $error("active in sleep");
  nm_clear_a: assert property (
    $stable(mode_o) && mode_o == lamp_switch_pkg::MODE_FAILSAFE |-> !normal_mode_flag_o)
    else $error("flag set in fail-safe");
  nm_set_a: assert property (
    (mode_o == lamp_switch_pkg::MODE_NORMAL)[*2] |-> normal_mode_flag_o)
    else $error("flag clear in normal");
  fault_mode_a: assert property (
    (prot_i != 12'h000 && mode_o != lamp_switch_pkg::MODE_SLEEP)[*3] |->
    mode_o == lamp_switch_pkg::MODE_FAULT) else $error("fault mode missed");
  fault_pin_a: assert property (
    (prot_i != 12'h000 && mode_o != lamp_switch_pkg::MODE_SLEEP)[*3] |-> !fault_pin_oe_n_o)
    else $error("fault pin released");
  uv_off_a: assert property (undervoltage_flag_i[*3] |-> output_drive_request_o == 4'h0)
    else $error("drive on undervoltage");
  so_release_a: assert property (cs_n_i[*6] |-> so_oe_n_o) else $error("so driven");
  so_drive_a: assert property ((!cs_n_i)[*6] |-> !so_oe_n_o) else $error("so idle");
  wd_off_a: assert property (
    (!failsafe_select_i && !vdd_fail_i)[*8] |-> mode_o != lamp_switch_pkg::MODE_FAILSAFE)
    else $error("fail-safe without cause");
  failsafe_c: cover property (mode_o == lamp_switch_pkg::MODE_FAILSAFE);
  fault_c: cover property (mode_o == lamp_switch_pkg::MODE_FAULT);
  clk_fail_c: cover property (pwm_clock_failure_flag_o);
endmodule
bind lamp_switch_mode_pwm_control lamp_switch_props u_props (
  .clk_i, .srst_i, .cs_n_i, .lamp_line_i, .wake_i, .sleep_release_i, .failsafe_select_i,
  .vdd_fail_i, .undervoltage_flag_i, .prot_i, .so_oe_n_o, .output_drive_request_o,
  .fault_pin_oe_n_o, .normal_mode_flag_o, .pwm_clock_failure_flag_o, .mode_o);
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the lamp switch mode and pwm control block
// assumes host_model drives the serial pins; long counts are shortened by parameters
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int TICK    = 8;
  localparam int READY   = 20;
  localparam int WDTO    = 2000;
  localparam int CMIN    = 300;
  localparam int CMAX    = 2000;
  localparam int EMIN    = 4;
  localparam int EMAX    = 64;
  localparam int CAL_LEN = 1600;
  logic                    clk = 1'b0;
  logic                    srst, sclk, cs_n, si, so, so_oe_n, wake, failsafe_select_input, uv, rel, vddf, ovf;
  logic                    fpin_n, fpin_oe_n, nm, cfail;
  logic [3:0]              lamp_line, drive;
  lamp_switch_pkg::prot_s  prot;
  lamp_switch_pkg::mode_e  mode;
  logic [15:0]             st;
  int                      fail_count, checks, hi, n, d;
  always #2 clk = ~clk;
  lamp_switch_mode_pwm_control #(.READY_CYC(READY), .WD_TO_CYC(WDTO), .CSB_MIN_CYC(CMIN),
    .CSB_MAX_CYC(CMAX), .INT_TICK_CYC(TICK), .EXT_MIN_CYC(EMIN), .EXT_MAX_CYC(EMAX)) dut (
    .clk_i(clk), .srst_i(srst), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so),
    .so_oe_n_o(so_oe_n), .lamp_line_i(lamp_line), .wake_i(wake), .sleep_release_i(rel),
    .failsafe_select_i(failsafe_select_input), .vdd_fail_i(vddf), .undervoltage_flag_i(uv),
    .supply_high_flag_i(ovf), .prot_i(prot), .output_drive_request_o(drive),
    .fault_pin_n_o(fpin_n), .fault_pin_oe_n_o(fpin_oe_n), .normal_mode_flag_o(nm),
    .pwm_clock_failure_flag_o(cfail), .mode_o(mode));
  host_model u_host (.clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so),
    .so_oe_n_i(so_oe_n));
  function automatic logic [3:0] direct_req(logic [3:0] on, logic [3:0] dis, logic [3:0] ln);
    return on | (ln & ~dis);
  endfunction
  function automatic int pwm_high(int duty);
    return (duty == 127) ? 128 * TICK : (duty + 1) * TICK;
  endfunction
  task automatic tick(input int c);
    repeat (c) @(negedge clk);
  endtask
  // waits one span, then counts the high cycles of channel 0 over the next
  task automatic high_time(input int span, output int h);
    tick(span);
    h = 0;
    repeat (span) begin
      @(negedge clk);
      h += drive[0];
    end
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic done(input string what);
    $display("test %s finished", what);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
  initial begin
    {srst, wake, failsafe_select_input, uv, lamp_line, prot} = {3'b100, 1'b0, 4'h0, 12'h000};
    {rel, vddf, ovf} = 3'b000;
    void'($urandom(32'h2b0b));
    tick(16);
    srst = 1'b0;
    tick(20);
    check("mode", mode, lamp_switch_pkg::MODE_SLEEP);
    check("drive", drive, 16'h0000);
    done("sleep");
    rel = 1'b1;
    tick(60);
    check("mode", mode, lamp_switch_pkg::MODE_NORMAL);
    wake = 1'b1;
    u_host.xfer(16'h6000, st);
    check("status", st, 16'hA000);
    u_host.xfer(16'h6000, st);
    check("status", st, 16'h8000);
    lamp_line = 4'hA;
    tick(10);
    check("drive", drive, direct_req(4'h0, 4'h0, 4'hA));
    u_host.xfer(16'h00F1, st);
    tick(4);
    check("drive", drive, direct_req(4'h1, 4'hF, 4'hA));
    lamp_line = 4'h0;
    done("direct");
    u_host.xfer(16'h0301, st);
    for (int k = 0; k < 4; k++) begin
      n = (k == 2) ? 127 : (k == 3) ? 0 : $urandom % 127;
      d = (k == 2) ? 7 : $urandom % 8;
      u_host.xfer({4'h1, 2'b00, d[2:0], n[6:0]}, st);
      // a delay shifts the wave but keeps the on-time of a whole period
      high_time(128 * TICK, hi);
      check("on_time", hi[15:0], 16'(pwm_high(n)));
    end
    // calibrated period is the select pulse over 128; a short pulse keeps it
    u_host.xfer(16'h5C5A, st);
    u_host.pulse(CAL_LEN);
    u_host.xfer(16'h101F, st);
    high_time(128 * (CAL_LEN / 128), hi);
    check("cal_on_time", hi[15:0], 16'(32 * (CAL_LEN / 128)));
    u_host.xfer(16'h5C5A, st);
    u_host.pulse(CMIN - 100);
    high_time(128 * (CAL_LEN / 128), hi);
    check("cal_keep", hi[15:0], 16'(32 * (CAL_LEN / 128)));
    // half duty with a half period delay: the two channels are complementary
    u_host.xfer(16'h0303, st);
    u_host.xfer(16'h103F, st);
    u_host.xfer(16'h223F, st);
    repeat (4) begin
      tick(97);
      check("stagger", 16'(drive[0] ^ drive[1]), 16'h0001);
    end
    u_host.xfer(16'h0101, st);
    tick(300);
    check("clk_fail", cfail, 16'h0001);
    check("drive", drive, 16'h0001);
    done("pwm");
    u_host.xfer(16'h0002, st);
    prot.overcurrent_flag[1] = 1'b1;
    tick(10);
    check("mode", mode, lamp_switch_pkg::MODE_FAULT);
    check("fault_pin", fpin_oe_n, 16'h0000);
    check("fault_pin_n", fpin_n, 16'h0000);
    prot = '0;
    tick(10);
    check("fault_pin", fpin_oe_n, 16'h0000);
    check("drive", drive, 16'h0000);
    u_host.xfer(16'h6000, st);
    check("status", st, 16'h8200);
    u_host.xfer(16'h0000, st);
    u_host.xfer(16'h0002, st);
    tick(4);
    check("fault_pin", fpin_oe_n, 16'h0001);
    check("drive", drive, 16'h0002);
    done("fault");
    failsafe_select_input = 1'b1;
    tick(10);
    lamp_line = 4'h8;
    tick(1000);
    u_host.xfer(16'hE000, st);
    tick(500);
    check("mode", mode, lamp_switch_pkg::MODE_NORMAL);
    tick(2100);
    check("mode", mode, lamp_switch_pkg::MODE_FAILSAFE);
    check("nm", nm, 16'h0000);
    lamp_line = 4'h5;
    tick(10);
    check("drive", drive, 16'h0005);
    u_host.xfer(16'h0001, st);
    tick(4);
    check("mode", mode, lamp_switch_pkg::MODE_NORMAL);
    // a supply loss latches fail-safe; only the exit word ends it
    u_host.xfer(16'h8400, st);
    vddf = 1'b1;
    tick(10);
    check("mode", mode, lamp_switch_pkg::MODE_FAILSAFE);
    vddf = 1'b0;
    tick(10);
    check("mode", mode, lamp_switch_pkg::MODE_FAILSAFE);
    u_host.xfer(16'h0001, st);
    tick(4);
    check("mode", mode, lamp_switch_pkg::MODE_NORMAL);
    failsafe_select_input = 1'b0;
    done("watchdog");
    ovf = 1'b1;
    tick(10);
    check("mode", mode, lamp_switch_pkg::MODE_NORMAL);
    check("drive", drive, 16'h0000);
    check("fault_pin", fpin_oe_n, 16'h0000);
    ovf = 1'b0;
    tick(10);
    check("drive", drive, 16'h0005);
    done("supply");
    uv = 1'b1;
    tick(10);
    check("drive", drive, 16'h0000);
    check("mode", mode, lamp_switch_pkg::MODE_FAULT);
    uv = 1'b0;
    done("undervoltage");
    wrap_up();
  end
endmodule
`default_nettype wire

// >>> verilog/lamp_switch_map.svh
// offsets, field positions, reset values and timing counts of the lamp switch control block
// assumes a 250 MHz core clock and 16-bit serial words shifted msb first
// What this block does
// - serial words are 16-bit full duplex, msb first both ways
// - sample input on falling clock, shift output on rising, latch at select rise
// - wake-up is sleep release, wake pin or any active lamp line
// - fail is enabled logic supply loss, or watchdog timeout with select input open
// - fault is any channel protection flag, undervoltage, or supply high with shutdown disabled
// - mode is sleep, normal, fail-safe or fault from wake-up, fail and fault
// - sleep turns outputs off and clears every configurable setting except the trim
// - normal mode flag is one in normal and zero in fail-safe
// - drive request is on bit or gated lamp line, or on bit and pwm
// - a channel's latched fault resets on its rearm signal
// - pwm clock is 128 times output rate, from lamp line 0 or oscillator
// - duty n gives (n+1)/128, all ones is fully on, on bit zero is off
// - each channel's pwm is delayed by its code times 16 pwm clocks
// - external pwm clock out of range sets failure flag, outputs follow on bits
// - after the trim command, a select low pulse sets oscillator period to length/128
// - a calibration pulse outside the window is ignored, trim kept
// - with select input open, rising wake, lamp line or sleep release arms watchdog
// - in fail-safe outputs follow lamp lines, settings default, protections active
// - exit fail-safe by exit bit with logic supply fine, or grounding select input unless a supply loss caused it
// - latched faults clear on every normal to fail-safe change and back
// - fault pin low while a fault exists; current, short, heat, undervoltage latch
// - fault report bits clear after the first valid transfer reports them
// - after sleep release, enter normal zeroed, report undervoltage, ready after 50 us
`ifndef LAMP_SWITCH_MAP_SVH
`define LAMP_SWITCH_MAP_SVH

`define WORD_BITS    5'd16
`define WD_BIT       15
`define ADDR_HI      14
`define ADDR_LO      12
`define EXIT_BIT     0
`define A_CTRL       3'h0
`define A_CHAN0      3'h1
`define A_TRIM       3'h5
// arbitrary calibration command value
`define CAL_CMD      12'hC5A
// pin vector reset: chip select idle high, the rest low
`define PIN_RST      10'h002
// wake, sleep release and the four lamp lines arm the watchdog
`define WD_ARM_MASK  10'h3D8
`define PWM_STEPS    128

`define CLK_MHZ      250
`define READY_US     50
`define READY_CYC    (`READY_US * `CLK_MHZ)
`define WD_TO_US     10000
`define WD_TO_CYC    (`WD_TO_US * `CLK_MHZ)
`define CSB_MIN_US   500
`define CSB_MIN_CYC  (`CSB_MIN_US * `CLK_MHZ)
`define CSB_MAX_US   2000
`define CSB_MAX_CYC  (`CSB_MAX_US * `CLK_MHZ)
`define INT_TICK_NS  40000
`define INT_TICK_CYC ((`INT_TICK_NS * `CLK_MHZ) / 1000)
`define EXT_MIN_NS   15000
`define EXT_MIN_CYC  ((`EXT_MIN_NS * `CLK_MHZ + 999) / 1000)
`define EXT_MAX_NS   100000
`define EXT_MAX_CYC  ((`EXT_MAX_NS * `CLK_MHZ) / 1000)

`endif

// >>> verilog/lamp_switch_mode_pwm_control.sv
// mode selection, serial word framing, watchdog, pwm and output control of a quad lamp switch
// assumes pins arrive asynchronously; protection and supply flags come on clk_i already
`include "lamp_switch_map.svh"
`timescale 1ns/10ps
`default_nettype none
module lamp_switch_mode_pwm_control #(
  parameter int READY_CYC    = `READY_CYC,
  parameter int WD_TO_CYC    = `WD_TO_CYC,
  parameter int CSB_MIN_CYC  = `CSB_MIN_CYC,
  parameter int CSB_MAX_CYC  = `CSB_MAX_CYC,
  parameter int INT_TICK_CYC = `INT_TICK_CYC,
  parameter int EXT_MIN_CYC  = `EXT_MIN_CYC,
  parameter int EXT_MAX_CYC  = `EXT_MAX_CYC
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  // serial link
  input  wire logic                   sclk_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   si_i,
  output logic                        so_o,
  output logic                        so_oe_n_o,
  // lamp and wake pins
  input  wire logic [3:0]             lamp_line_i,
  input  wire logic                   wake_i,
  input  wire logic                   sleep_release_i,
  input  wire logic                   failsafe_select_i,
  // supply and protection flags
  input  wire logic                   vdd_fail_i,
  input  wire logic                   undervoltage_flag_i,
  input  wire logic                   supply_high_flag_i,
  input  wire lamp_switch_pkg::prot_s prot_i,
  // outputs
  output logic [3:0]                  output_drive_request_o,
  output logic                        fault_pin_n_o,
  output logic                        fault_pin_oe_n_o,
  output logic                        normal_mode_flag_o,
  output logic                        pwm_clock_failure_flag_o,
  output lamp_switch_pkg::mode_e      mode_o
);
  localparam int P_SCLK = 0;
  localparam int P_CS   = 1;
  localparam int P_SI   = 2;
  localparam int P_RST  = 4;
  localparam int P_WAKE = 3;
  localparam int P_FSI  = 5;
  localparam int P_LAMP = 6;

  lamp_switch_pkg::state_s q;
  lamp_switch_pkg::state_s n;
  logic [9:0]  raw;
  logic [9:0]  rise;
  logic [9:0]  fall;
  logic [3:0]  lamp;
  logic [3:0]  wave;
  logic [3:0]  rearm;
  logic [3:0]  cond;
  logic [3:0]  req;
  logic [13:0] events;
  logic [2:0]  addr;
  logic        wake_up;
  logic        fault_c;
  logic        fail_set;
  logic        word_ok;
  logic        ov_off;
  logic        int_tick;
  logic        ext_tick;
  logic        tick;
  logic        clk_bad;
  logic        use_pwm;

  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic [6:0] slot;
    // phase shift by delay code times 16 pwm clocks
    assign slot     = q.phase - {q.chan[c].delay, 4'h0};
    assign wave[c]  = (slot <= q.chan[c].duty);
    assign rearm[c] = q.ctrl.on[c] | (~q.ctrl.pwm_en & lamp[c] & ~q.ctrl.dir_dis[c]);
  end

  always_comb begin
    n = q;
    // three stages; a level counts once stages two and three agree
    raw = {lamp_line_i, failsafe_select_i, sleep_release_i, wake_i, si_i, cs_n_i, sclk_i};
    n.s1 = raw;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.pin = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.pin);
    rise = n.pin & ~q.pin;
    fall = q.pin & ~n.pin;
    lamp = q.pin[P_LAMP +: 4];
    addr = q.rx[`ADDR_HI:`ADDR_LO];

    wake_up = q.pin[P_RST] | q.pin[P_WAKE] | (|lamp);
    cond = prot_i.overcurrent_flag | prot_i.overtemp_flag | prot_i.severe_short_flag;
    fault_c = (|cond) | (|q.latched) | undervoltage_flag_i
            | (supply_high_flag_i & q.ctrl.supply_high_shutdown_disable);
    ov_off = supply_high_flag_i & ~q.ctrl.supply_high_shutdown_disable;
    fail_set = (vdd_fail_i & q.ctrl.vdd_en) | (q.wd_exp & q.pin[P_FSI]);

    if (!wake_up) begin
      n.mode = lamp_switch_pkg::MODE_SLEEP;
    end else if (fault_c) begin
      n.mode = lamp_switch_pkg::MODE_FAULT;
    end else if (q.fs | fail_set) begin
      n.mode = lamp_switch_pkg::MODE_FAILSAFE;
    end else begin
      n.mode = lamp_switch_pkg::MODE_NORMAL;
    end

    // serial shifter: status loads at select fall, words count only at 16 bits
    word_ok = rise[P_CS] && (q.bits == `WORD_BITS);
    if (fall[P_CS]) begin
      n.tx = {q.nm, q.clk_flag, q.rep};
      n.snap = q.rep;
      n.bits = 5'h00;
    end else if (!q.pin[P_CS]) begin
      if (fall[P_SCLK]) begin
        n.rx = {q.rx[14:0], q.pin[P_SI]};
        if (q.bits != 5'h11) begin
          n.bits = q.bits + 5'h01;
        end
      end
      // the first rising edge leaves the msb on the line
      if (rise[P_SCLK] && q.bits != 5'h00) begin
        n.tx = {q.tx[14:0], q.pin[P_SI]};
      end
    end

    // report bits clear after being shifted out in a 16-bit word, and in sleep; new events still win
    events = {undervoltage_flag_i, supply_high_flag_i, prot_i};
    if (q.mode == lamp_switch_pkg::MODE_SLEEP && n.mode != lamp_switch_pkg::MODE_SLEEP) begin
      events[13] = 1'b1;
    end
    n.rep = (q.rep & ~(word_ok ? q.snap : 14'h0000)) | events;

    // watchdog
    if (q.wd_run) begin
      n.wd_cnt = q.wd_cnt + 24'h000001;
      if (q.wd_cnt >= 24'(WD_TO_CYC - 1)) begin
        n.wd_exp = 1'b1;
        n.wd_run = 1'b0;
      end
    end
    if (q.pin[P_FSI] && (|(rise & `WD_ARM_MASK))) begin
      n.wd_run = 1'b1;
      n.wd_cnt = 24'h000000;
    end
    if (word_ok) begin
      n.wd_last = q.rx[`WD_BIT];
      if (q.rx[`WD_BIT] != q.wd_last) begin
        n.wd_cnt = 24'h000000;
      end
    end
    if (!q.pin[P_FSI]) begin
      n.wd_run = 1'b0;
      n.wd_exp = 1'b0;
    end

    // fail-safe latch and its exits
    if (fail_set) begin
      n.fs = 1'b1;
      n.fs_vdd = q.fs_vdd | (vdd_fail_i & q.ctrl.vdd_en);
    end
    if (q.fs && word_ok && q.rx[`EXIT_BIT] && !vdd_fail_i) begin
      n.fs = 1'b0;
      n.fs_vdd = 1'b0;
      n.wd_exp = 1'b0;
      n.wd_cnt = 24'h000000;
    end
    if (q.fs && !q.fs_vdd && !q.pin[P_FSI]) begin
      n.fs = 1'b0;
    end

    // configuration writes; ignored in fail-safe
    if (word_ok && !q.fs) begin
      case (addr)
        `A_CTRL: n.ctrl = lamp_switch_pkg::ctrl_s'(q.rx[11:0]);
        `A_TRIM: n.cal_arm = (q.rx[11:0] == `CAL_CMD);
        default: begin
          if (addr >= `A_CHAN0 && addr < `A_CHAN0 + 3'h4) begin
            n.chan[2'(addr - `A_CHAN0)] = lamp_switch_pkg::chan_cfg_s'(q.rx[9:0]);
          end
        end
      endcase
    end

    // calibration pulse measured from select fall to rise
    if (q.cal_run && q.cal_cnt != 24'hFFFFFF) begin
      n.cal_cnt = q.cal_cnt + 24'h000001;
    end
    if (fall[P_CS] && q.cal_arm) begin
      n.cal_arm = 1'b0;
      n.cal_run = 1'b1;
      n.cal_cnt = 24'h000000;
    end
    if (rise[P_CS] && q.cal_run) begin
      n.cal_run = 1'b0;
      if (q.cal_cnt >= 24'(CSB_MIN_CYC) && q.cal_cnt <= 24'(CSB_MAX_CYC)) begin
        n.trim = 16'(q.cal_cnt / `PWM_STEPS);
      end
    end

    // pwm clock source and phase
    int_tick = (q.tick_cnt >= q.trim - 16'h0001);
    n.tick_cnt = int_tick ? 16'h0000 : q.tick_cnt + 16'h0001;
    ext_tick = rise[P_LAMP];
    tick = q.ctrl.clk_sel ? int_tick : ext_tick;
    if (tick) begin
      n.phase = q.phase + 7'h01;
    end

    // external clock period monitor; a stopped clock also fails
    if (q.mon_cnt < 16'(EXT_MAX_CYC)) begin
      n.mon_cnt = q.mon_cnt + 16'h0001;
    end else begin
      n.clk_fail = 1'b1;
    end
    if (ext_tick) begin
      n.mon_cnt = 16'h0000;
      n.clk_fail = (q.mon_cnt < 16'(EXT_MIN_CYC - 1));
    end
    clk_bad = q.clk_fail & q.ctrl.pwm_en & ~q.ctrl.clk_sel;
    use_pwm = q.ctrl.pwm_en & ~clk_bad;
    n.clk_flag = clk_bad;

    // latched faults: cleared by a rearm rise or a fail-safe entry or exit, set wins
    n.rearm_q = rearm;
    n.latched = q.latched & ~(rearm & ~q.rearm_q);
    if (n.fs != q.fs) begin
      n.latched = 4'h0;
    end
    n.latched = n.latched | ((cond | {4{undervoltage_flag_i}}) & rearm);

    if (q.ready_cnt < 16'(READY_CYC - 1)) begin
      n.ready_cnt = q.ready_cnt + 16'h0001;
    end else begin
      n.ready = 1'b1;
    end

    // fail-safe leaves the settings at zero, so requests follow the lamp lines
    if (use_pwm) begin
      req = q.ctrl.on & wave;
    end else if (clk_bad) begin
      req = q.ctrl.on;
    end else begin
      req = q.ctrl.on | (lamp & ~q.ctrl.dir_dis);
    end
    if (q.mode == lamp_switch_pkg::MODE_SLEEP || !q.ready || undervoltage_flag_i || ov_off) begin
      n.drive = 4'h0;
    end else begin
      n.drive = req & ~q.latched & ~cond;
    end
    // open load is never an input here: it must not pull the pin
    n.fault_n = ~(fault_c | ov_off);

    if (n.mode == lamp_switch_pkg::MODE_SLEEP || n.fs) begin
      n.ctrl = '0;
      n.chan = '0;
      n.cal_arm = 1'b0;
    end
    if (n.mode == lamp_switch_pkg::MODE_SLEEP) begin
      n.wd_run = 1'b0;
      n.wd_exp = 1'b0;
      n.fs = 1'b0;
      n.fs_vdd = 1'b0;
      n.latched = 4'h0;
      n.rep = 14'h0000;
      n.ready = 1'b0;
      n.ready_cnt = 16'h0000;
      n.phase = 7'h00;
      n.cal_run = 1'b0;
      n.drive = 4'h0;
    end
    // the mode lags the fail-safe latch by a cycle on exit; the flag is low in sleep, in fail-safe or while the latch is set
    n.nm = (n.mode != lamp_switch_pkg::MODE_SLEEP) && (n.mode != lamp_switch_pkg::MODE_FAILSAFE)
         && !n.fs;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
      q.s1 <= `PIN_RST;
      q.s2 <= `PIN_RST;
      q.s3 <= `PIN_RST;
      q.pin <= `PIN_RST;
      q.trim <= 16'(INT_TICK_CYC);
      q.fault_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign so_o                     = q.tx[15];
  assign so_oe_n_o                = q.pin[P_CS];
  assign output_drive_request_o   = q.drive;
  assign fault_pin_n_o            = 1'b0;
  assign fault_pin_oe_n_o         = q.fault_n;
  assign normal_mode_flag_o       = q.nm;
  assign pwm_clock_failure_flag_o = q.clk_flag;
  assign mode_o                   = q.mode;
endmodule
`default_nettype wire

// >>> verilog/lamp_switch_pkg.sv
// types of the lamp switch mode and pwm control block
// assumes nothing beyond the constants header
package lamp_switch_pkg;
  typedef enum logic [1:0] {MODE_SLEEP, MODE_NORMAL, MODE_FAILSAFE, MODE_FAULT} mode_e;
  // layouts match the low data bits of a serial word
  typedef struct packed {
    logic       supply_high_shutdown_disable;
    logic       vdd_en;
    logic       clk_sel;
    logic       pwm_en;
    logic [3:0] dir_dis;
    logic [3:0] on;
  } ctrl_s;
  typedef struct packed {
    logic [2:0] delay;
    logic [6:0] duty;
  } chan_cfg_s;
  typedef struct packed {
    logic [3:0] overcurrent_flag;
    logic [3:0] overtemp_flag;
    logic [3:0] severe_short_flag;
  } prot_s;
  typedef struct packed {
    logic [9:0]       s1, s2, s3, pin;
    mode_e            mode;
    ctrl_s            ctrl;
    chan_cfg_s [3:0]  chan;
    logic [15:0]      rx, tx;
    logic [4:0]       bits;
    logic             wd_last, wd_run, wd_exp;
    logic [23:0]      wd_cnt;
    logic             fs, fs_vdd;
    logic [3:0]       latched, rearm_q;
    logic [13:0]      rep, snap;
    logic             cal_arm, cal_run;
    logic [23:0]      cal_cnt;
    logic [15:0]      trim, tick_cnt, mon_cnt, ready_cnt;
    logic [6:0]       phase;
    logic             clk_fail, clk_flag, ready, nm, fault_n;
    logic [3:0]       drive;
  } state_s;
endpackage
